// File: core/pbm_cfg.svh
`ifndef PBM_CFG_SVH
`define PBM_CFG_SVH

// ==========================================================================
// Pin positions and counts
// ==========================================================================
// Port B pin count and index of each pin with an alternate function.
`define PBM_NPIN 8
`define PBM_PB7 3'h7
`define PBM_PB6 3'h6
`define PBM_PB5 3'h5
`define PBM_PB4 3'h4
`define PBM_PB3 3'h3
`define PBM_PB2 3'h2
`define PBM_PB1 3'h1
`define PBM_PB0 3'h0

// Synchroniser lanes: eight port B pins, then port D pins 7, 4 and 1.
`define PBM_NSYNC 11
`define PBM_LANE_PD7 4'h8
`define PBM_LANE_PD4 4'h9
`define PBM_LANE_PD1 4'ha

// ==========================================================================
// Encodings and reset values
// ==========================================================================
// Pattern of {direction, output data, global disable} that turns a pull-up on.
`define PBM_PULLUP_PATTERN 3'h2
// Reset value of every synchroniser stage and of the port B read-back.
`define PBM_SYNC_RESET 11'h000
`define PBM_PIN_RESET 8'h00

`endif

// File: core/pbm_pkg.sv
`default_nettype none

// ==========================================================================
// Types shared by the port B override logic
// ==========================================================================
package pbm_pkg;

  // Override set that a peripheral hands to one pin.
  typedef struct packed {
    logic pullup_ovr_en;
    logic pullup_ovr_val;
    logic dir_ovr_en;
    logic dir_ovr_val;
    logic value_ovr_en;
    logic value_ovr_val;
    logic din_ovr_en;
    logic din_ovr_val;
  } pbm_ovr_type;

  // Resolved pin control for one pin.
  typedef struct packed {
    logic pullup_on;
    logic drive_en;
    logic drive_val;
    logic din_on;
  } pbm_pin_type;

  // Enables of the peripherals that take over port B pins.
  typedef struct packed {
    logic spi_on;
    logic spi_master_select;
    logic stage2_out0_on;
    logic stage2_out1_on;
    logic stage2_out2_on;
    logic stage2_out3_on;
    logic stage_sec_out1_on;
    logic cmp3_output_on;
    logic ext_irq0_on;
    logic ext_irq1_on;
  } pbm_periph_en_type;

  // Output levels of those peripherals.
  typedef struct packed {
    logic spi_miso_out;
    logic spi_sck_out;
    logic spi_mosi_out;
    logic stage2_pwm_out0;
    logic stage2_pwm_out1;
    logic stage2_pwm_out2;
    logic stage2_pwm_out3;
    logic stage_sec_pwm_out1;
    logic cmp3_result;
  } pbm_periph_out_type;

  // Converter and comparator digital input disables.
  typedef struct packed {
    logic conv_ch9_din_off;
    logic conv_ch8_din_off;
    logic conv_ch5_din_off;
    logic conv_ch3_din_off;
    logic conv_ch2_din_off;
    logic conv_ch10_din_off;
    logic conv_ch4_din_off;
  } pbm_conv_off_type;

  // Inputs delivered to the peripherals.
  typedef struct packed {
    logic timer_capture_in;
    logic timer_count_src;
    logic ext_irq_src0;
    logic ext_irq_src1;
    logic spi_miso_in;
    logic spi_sck_in;
    logic spi_mosi_in;
    logic stage_sec_alt_in_a;
    logic stage_sec_alt_in_b;
    logic stage2_alt_in;
  } pbm_periph_in_type;

  // Whole register state of the top module.
  typedef struct packed {
    logic [10:0] sync1;
    logic [10:0] sync2;
    logic [10:0] sync3;
    logic [10:0] stable;
    logic [7:0] pb_read;
    pbm_periph_in_type periph_in;
  } pbm_state_type;

endpackage

`default_nettype wire

// File: core/pbm_pin_ctrl.sv
`timescale 1ns/10ps
`default_nettype none

`include "pbm_cfg.svh"

// ==========================================================================
// Resolution of one pin's overrides against its port register bits
// ==========================================================================
module pbm_pin_ctrl
  import pbm_pkg::*;
(
  // Overrides from the alternate function.
  input wire pbm_ovr_type ovr,
  // Port register bits of this pin.
  input wire logic dir_bit,
  input wire logic out_data_bit,
  input wire logic global_pullup_disable,
  // Core sleep state, which normally switches the digital input off.
  input wire logic mcu_sleep,
  // Resolved control.
  output pbm_pin_type pin
);

  // Purely combinational so a peripheral enable reaches the pad at once.
  always_comb begin
    if (ovr.pullup_ovr_en) begin
      pin.pullup_on = ovr.pullup_ovr_val;
    end else begin
      pin.pullup_on = ({dir_bit, out_data_bit, global_pullup_disable} ==
                       `PBM_PULLUP_PATTERN);
    end
    pin.drive_en = ovr.dir_ovr_en ? ovr.dir_ovr_val : dir_bit;
    pin.drive_val = ovr.value_ovr_en ? ovr.value_ovr_val : out_data_bit;
    pin.din_on = ovr.din_ovr_en ? ovr.din_ovr_val : !mcu_sleep;
  end

endmodule

`default_nettype wire

// File: core/pbm_port_b_mux.sv
// Notes on behaviour
// - SPI master forces pin B6 to input regardless of its direction bit.
// - SPI slave leaves pin B6 direction to its direction bit.
// - Forced-input B6 pull-up follows its data bit and global disable.
// - SPI slave forces clock pin B5 to input; master uses direction bit.
// - Forced-input B5 pull-up still follows its data bit.
// - SPI slave forces data-out pin B4 to input; master uses direction bit.
// - Forced-input B4 pull-up follows its data bit and global disable.
// - B7 drives stage2 output 2 when enabled; gated input feeds timer capture.
// - SPI pin overrides come from SPI enable and mode; direction value 0.
// - B5 input enable override follows converter ch5 disable or interrupt 1 enable; value follows interrupt 1 enable; feeds it.
// - B3..B1 become outputs driving their stage output when enabled.
// - B0 drives stage output 3, else comparator 3, else follows its direction and data bits.
// - B2 input enable override and value follow interrupt 0 enable; feeds it.
// - D7, D1 feed secondary stage alt inputs; D4 feeds stage2 alt input.
// - Pull-up follows override when enabled, else on only for pattern 010.
// - Direction override enable lets its value decide the output driver.
// - Value override replaces the data bit while the driver is on.
// - Input enable override decides the digital input regardless of sleep.
`timescale 1ns/10ps
`default_nettype none

`include "pbm_cfg.svh"

// ==========================================================================
// Port B alternate function override mux
// ==========================================================================
module pbm_port_b_mux
  import pbm_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_b,
  // Port B register bits and global controls.
  input wire logic [7:0] port_b_dir,
  input wire logic [7:0] port_b_out_data,
  input wire logic global_pullup_disable,
  input wire logic mcu_sleep,
  // Peripheral enables, outputs and converter input disables.
  input wire pbm_periph_en_type periph_en,
  input wire pbm_periph_out_type periph_out,
  input wire pbm_conv_off_type conv_off,
  // Port B pads: input, output level, output enable and pull-up.
  input wire logic [7:0] pb_pad_in,
  output logic [7:0] pb_pad_out,
  output logic [7:0] pb_pad_oe,
  output logic [7:0] pb_pullup_on,
  // Port D pads whose inputs are routed here.
  input wire logic pd7_pad_in,
  input wire logic pd4_pad_in,
  input wire logic pd1_pad_in,
  // Synchronised, gated pin levels for the port read-back.
  output logic [7:0] pb_pin_read,
  // Inputs delivered to the peripherals.
  output pbm_periph_in_type periph_in
);

  // ========================================================================
  // Override generation
  // ========================================================================
  pbm_ovr_type ovr [`PBM_NPIN];
  pbm_pin_type pin [`PBM_NPIN];
  logic spi_master;
  logic spi_slave;

  assign spi_master = periph_en.spi_on && periph_en.spi_master_select;
  assign spi_slave = periph_en.spi_on && !periph_en.spi_master_select;

  // Every override is decoded straight from the live enables, so there is
  // no lag between a peripheral switching on and the pad following.
  always_comb begin
    for (int i = 0; i < `PBM_NPIN; i++) begin
      ovr[i] = '0;
    end

    // B7: stage2 output 2, capture input behind the converter disable.
    ovr[`PBM_PB7].dir_ovr_en = periph_en.stage2_out2_on;
    ovr[`PBM_PB7].dir_ovr_val = 1'h1;
    ovr[`PBM_PB7].value_ovr_en = periph_en.stage2_out2_on;
    ovr[`PBM_PB7].value_ovr_val = periph_out.stage2_pwm_out2;
    ovr[`PBM_PB7].din_ovr_en = conv_off.conv_ch9_din_off;

    // B6: data-in as master, so forced to input; driven as slave by the SPI
    // only where its own direction bit enables the driver.
    ovr[`PBM_PB6].pullup_ovr_en = spi_master;
    ovr[`PBM_PB6].pullup_ovr_val = port_b_out_data[`PBM_PB6] &&
                                   !global_pullup_disable;
    ovr[`PBM_PB6].dir_ovr_en = spi_master;
    ovr[`PBM_PB6].dir_ovr_val = 1'h0;
    ovr[`PBM_PB6].value_ovr_en = spi_slave;
    ovr[`PBM_PB6].value_ovr_val = periph_out.spi_miso_out;
    ovr[`PBM_PB6].din_ovr_en = conv_off.conv_ch8_din_off;

    // B5: clock pin, forced to input as slave; also interrupt 1 source.
    ovr[`PBM_PB5].pullup_ovr_en = spi_slave;
    ovr[`PBM_PB5].pullup_ovr_val = port_b_out_data[`PBM_PB5] &&
                                   !global_pullup_disable;
    ovr[`PBM_PB5].dir_ovr_en = spi_slave;
    ovr[`PBM_PB5].dir_ovr_val = 1'h0;
    ovr[`PBM_PB5].value_ovr_en = spi_master;
    ovr[`PBM_PB5].value_ovr_val = periph_out.spi_sck_out;
    ovr[`PBM_PB5].din_ovr_en = conv_off.conv_ch5_din_off ||
                               periph_en.ext_irq1_on;
    ovr[`PBM_PB5].din_ovr_val = periph_en.ext_irq1_on;

    // B4: master data-out, forced to input as slave.
    ovr[`PBM_PB4].pullup_ovr_en = spi_slave;
    ovr[`PBM_PB4].pullup_ovr_val = port_b_out_data[`PBM_PB4] &&
                                   !global_pullup_disable;
    ovr[`PBM_PB4].dir_ovr_en = spi_slave;
    ovr[`PBM_PB4].dir_ovr_val = 1'h0;
    ovr[`PBM_PB4].value_ovr_en = spi_master;
    ovr[`PBM_PB4].value_ovr_val = periph_out.spi_mosi_out;
    ovr[`PBM_PB4].din_ovr_en = conv_off.conv_ch3_din_off;

    // B3: secondary stage output 1.
    ovr[`PBM_PB3].dir_ovr_en = periph_en.stage_sec_out1_on;
    ovr[`PBM_PB3].dir_ovr_val = 1'h1;
    ovr[`PBM_PB3].value_ovr_en = periph_en.stage_sec_out1_on;
    ovr[`PBM_PB3].value_ovr_val = periph_out.stage_sec_pwm_out1;
    ovr[`PBM_PB3].din_ovr_en = conv_off.conv_ch2_din_off;

    // B2: stage2 output 1 and interrupt 0 source.
    ovr[`PBM_PB2].dir_ovr_en = periph_en.stage2_out1_on;
    ovr[`PBM_PB2].dir_ovr_val = 1'h1;
    ovr[`PBM_PB2].value_ovr_en = periph_en.stage2_out1_on;
    ovr[`PBM_PB2].value_ovr_val = periph_out.stage2_pwm_out1;
    ovr[`PBM_PB2].din_ovr_en = periph_en.ext_irq0_on;
    ovr[`PBM_PB2].din_ovr_val = periph_en.ext_irq0_on;

    // B1: stage2 output 0; no input override at all.
    ovr[`PBM_PB1].dir_ovr_en = periph_en.stage2_out0_on;
    ovr[`PBM_PB1].dir_ovr_val = 1'h1;
    ovr[`PBM_PB1].value_ovr_en = periph_en.stage2_out0_on;
    ovr[`PBM_PB1].value_ovr_val = periph_out.stage2_pwm_out0;

    // B0: stage2 output 3 has priority over the comparator 3 result.
    ovr[`PBM_PB0].dir_ovr_en = periph_en.stage2_out3_on ||
                               periph_en.cmp3_output_on;
    ovr[`PBM_PB0].dir_ovr_val = 1'h1;
    ovr[`PBM_PB0].value_ovr_en = ovr[`PBM_PB0].dir_ovr_en;
    if (periph_en.stage2_out3_on) begin
      ovr[`PBM_PB0].value_ovr_val = periph_out.stage2_pwm_out3;
    end else if (periph_en.cmp3_output_on) begin
      ovr[`PBM_PB0].value_ovr_val = periph_out.cmp3_result;
    end else begin
      ovr[`PBM_PB0].value_ovr_val = 1'h0;
    end
  end

  // ========================================================================
  // Per-pin resolution
  // ========================================================================
  // One resolver per pin; the pad outputs stay combinational on purpose.
  for (genvar g = 0; g < `PBM_NPIN; g++) begin : g_pin
    pbm_pin_ctrl pbm_pin_ctrl_i (
      .ovr(ovr[g]),
      .dir_bit(port_b_dir[g]),
      .out_data_bit(port_b_out_data[g]),
      .global_pullup_disable(global_pullup_disable),
      .mcu_sleep(mcu_sleep),
      .pin(pin[g])
    );
    assign pb_pad_oe[g] = pin[g].drive_en;
    assign pb_pad_out[g] = pin[g].drive_val;
    assign pb_pullup_on[g] = pin[g].pullup_on;
  end

  // ========================================================================
  // Input synchronisation and routing
  // ========================================================================
  pbm_state_type state_q;
  pbm_state_type state_d;
  logic [7:0] din_on;
  logic [10:0] pad_in;

  always_comb begin
    for (int i = 0; i < `PBM_NPIN; i++) begin
      din_on[i] = pin[i].din_on;
    end
  end

  assign pad_in = {pd1_pad_in, pd4_pad_in, pd7_pad_in, pb_pad_in};

  // Pads are asynchronous: three stages, and a level is taken only once the
  // second and third agree, which filters a single-cycle glitch. A disabled
  // digital input reads as zero, as the pad's input buffer would.
  always_comb begin
    state_d = state_q;
    state_d.sync1 = pad_in;
    state_d.sync2 = state_q.sync1;
    state_d.sync3 = state_q.sync2;
    for (int i = 0; i < `PBM_NSYNC; i++) begin
      if (state_q.sync2[i] == state_q.sync3[i]) begin
        state_d.stable[i] = state_q.sync3[i];
      end
    end
    state_d.pb_read = state_d.stable[7:0] & din_on;
    state_d.periph_in.timer_capture_in = state_d.pb_read[`PBM_PB7];
    state_d.periph_in.spi_miso_in = state_d.pb_read[`PBM_PB6];
    state_d.periph_in.spi_sck_in = state_d.pb_read[`PBM_PB5];
    state_d.periph_in.ext_irq_src1 = state_d.pb_read[`PBM_PB5];
    state_d.periph_in.spi_mosi_in = state_d.pb_read[`PBM_PB4];
    state_d.periph_in.ext_irq_src0 = state_d.pb_read[`PBM_PB2];
    state_d.periph_in.timer_count_src = state_d.pb_read[`PBM_PB0];
    state_d.periph_in.stage_sec_alt_in_a = state_d.stable[`PBM_LANE_PD7] &&
                                           !conv_off.conv_ch10_din_off;
    state_d.periph_in.stage2_alt_in = state_d.stable[`PBM_LANE_PD4] &&
                                      !conv_off.conv_ch4_din_off;
    state_d.periph_in.stage_sec_alt_in_b = state_d.stable[`PBM_LANE_PD1];
  end

  // Synchronous reset clears every stage and every delivered input.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_q.sync1 <= `PBM_SYNC_RESET;
      state_q.sync2 <= `PBM_SYNC_RESET;
      state_q.sync3 <= `PBM_SYNC_RESET;
      state_q.stable <= `PBM_SYNC_RESET;
      state_q.pb_read <= `PBM_PIN_RESET;
      state_q.periph_in <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign pb_pin_read = state_q.pb_read;
  assign periph_in = state_q.periph_in;

endmodule

`default_nettype wire

// File: sim/pbm_port_b_mux_checker.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// Port-level checks of the port B override mux
// ==========================================================================
module pbm_port_b_mux_checker
  import pbm_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_b,
  // Port register bits and peripheral side.
  input wire logic [7:0] port_b_dir,
  input wire logic [7:0] port_b_out_data,
  input wire logic global_pullup_disable,
  input wire pbm_periph_en_type periph_en,
  input wire pbm_periph_out_type periph_out,
  input wire pbm_periph_in_type periph_in,
  // Pads.
  input wire logic [7:0] pb_pad_in,
  input wire logic [7:0] pb_pad_out,
  input wire logic [7:0] pb_pad_oe,
  input wire logic [7:0] pb_pullup_on
);
  logic mst;
  logic slv;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  // SPI mode decode used by the five SPI pin checks.
  assign mst = periph_en.spi_on & periph_en.spi_master_select;
  assign slv = periph_en.spi_on & ~periph_en.spi_master_select;

  a_miso_forced_in: assert property (
    mst |-> !pb_pad_oe[6] && pb_pullup_on[6] == (port_b_out_data[6] & !global_pullup_disable))
    else $error("Master mode left B6 driven or lost its pull-up control.");
  a_miso_slave_dir: assert property (
    slv |-> pb_pad_oe[6] == port_b_dir[6] && pb_pad_out[6] == periph_out.spi_miso_out)
    else $error("Slave mode B6 direction or value wrong.");
  a_sck_slave_in: assert property (
    slv |-> !pb_pad_oe[5] && pb_pullup_on[5] == (port_b_out_data[5] & !global_pullup_disable))
    else $error("Slave mode left B5 driven.");
  a_mosi_slave_in: assert property (
    slv |-> !pb_pad_oe[4] && pb_pullup_on[4] == (port_b_out_data[4] & !global_pullup_disable))
    else $error("Slave mode left B4 driven.");
  a_sck_master_out: assert property (
    mst |-> pb_pad_oe[5] == port_b_dir[5] &&
    (!port_b_dir[5] || pb_pad_out[5] == periph_out.spi_sck_out))
    else $error("Master mode B5 does not carry the SPI clock.");
  a_b7_stage_drive: assert property (
    periph_en.stage2_out2_on |-> pb_pad_oe[7] && pb_pad_out[7] == periph_out.stage2_pwm_out2)
    else $error("B7 does not drive stage output 2.");
  a_b3_sec_drive: assert property (
    periph_en.stage_sec_out1_on |-> pb_pad_oe[3] && pb_pad_out[3] == periph_out.stage_sec_pwm_out1)
    else $error("B3 does not drive the secondary stage output.");
  a_b0_out_priority: assert property (
    periph_en.stage2_out3_on || periph_en.cmp3_output_on |-> pb_pad_oe[0] && pb_pad_out[0] ==
    (periph_en.stage2_out3_on ? periph_out.stage2_pwm_out3 : periph_out.cmp3_result))
    else $error("B0 output priority wrong.");
  a_b7_pullup_plain: assert property (
    pb_pullup_on[7] == ({port_b_dir[7], port_b_out_data[7], global_pullup_disable} == 3'h2))
    else $error("B7 default pull-up wrong.");
  a_irq0_route: assert property (
    (periph_en.ext_irq0_on && $stable(pb_pad_in[2]))[*5] |->
    periph_in.ext_irq_src0 == pb_pad_in[2])
    else $error("B2 level not delivered to interrupt 0.");
  a_irq1_route: assert property (
    (periph_en.ext_irq1_on && $stable(pb_pad_in[5]))[*5] |->
    periph_in.ext_irq_src1 == pb_pad_in[5])
    else $error("B5 level not delivered to interrupt 1.");
endmodule

bind pbm_port_b_mux pbm_port_b_mux_checker pbm_port_b_mux_checker_i (
  .clk_sys(clk_sys),
  .rst_b(rst_b),
  .port_b_dir(port_b_dir),
  .port_b_out_data(port_b_out_data),
  .global_pullup_disable(global_pullup_disable),
  .periph_en(periph_en),
  .periph_out(periph_out),
  .periph_in(periph_in),
  .pb_pad_in(pb_pad_in),
  .pb_pad_out(pb_pad_out),
  .pb_pad_oe(pb_pad_oe),
  .pb_pullup_on(pb_pullup_on)
);

`default_nettype wire

// File: sim/pbm_periph_model.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// Peripheral side: levels that the SPI, stage controllers and comparator drive
// ==========================================================================
module pbm_periph_model
  import pbm_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_b,
  // Delivered inputs and driven levels.
  input wire pbm_periph_in_type periph_in,
  output pbm_periph_out_type periph_out
);
  logic [8:0] pat_q;

  // Levels change every cycle, so a stuck override path cannot hide.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pat_q <= 9'h1a5;
    end else begin
      pat_q <= {pat_q[7:0], pat_q[8] ^ pat_q[4]};
    end
  end

  // Slave data out is the master data line XORed with the top pattern bit.
  assign periph_out = {pat_q[8] ^ periph_in.spi_mosi_in, pat_q[7:0]};
endmodule

`default_nettype wire

// File: sim/pbm_port_b_mux_bench.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// Self-checking bench of the port B override mux
// ==========================================================================
module pbm_port_b_mux_bench
  import pbm_pkg::*;
;
  logic clk_sys = 1'h0;
  logic rst_b = 1'h0;
  logic [7:0] port_b_dir = 8'h00;
  logic [7:0] port_b_out_data = 8'h00;
  logic [7:0] pb_pad_in = 8'h00;
  logic [7:0] pb_pad_out, pb_pad_oe, pb_pullup_on, pb_pin_read, rd;
  logic global_pullup_disable = 1'h0;
  logic mcu_sleep = 1'h0;
  logic pd7_pad_in = 1'h0;
  logic pd4_pad_in = 1'h0;
  logic pd1_pad_in = 1'h0;
  pbm_periph_en_type periph_en = '0;
  pbm_conv_off_type conv_off = '0;
  pbm_periph_out_type periph_out;
  pbm_periph_in_type periph_in, pe;
  int err_total = 0;
  int tests_run = 0;

  // Clock of 100 ns period.
  always #50 clk_sys = ~clk_sys;

  pbm_port_b_mux pbm_port_b_mux_i (.clk_sys(clk_sys), .rst_b(rst_b), .port_b_dir(port_b_dir),
    .port_b_out_data(port_b_out_data), .global_pullup_disable(global_pullup_disable),
    .mcu_sleep(mcu_sleep), .periph_en(periph_en), .periph_out(periph_out), .conv_off(conv_off),
    .pb_pad_in(pb_pad_in), .pb_pad_out(pb_pad_out), .pb_pad_oe(pb_pad_oe),
    .pb_pullup_on(pb_pullup_on), .pd7_pad_in(pd7_pad_in), .pd4_pad_in(pd4_pad_in),
    .pd1_pad_in(pd1_pad_in), .pb_pin_read(pb_pin_read), .periph_in(periph_in));
  pbm_periph_model pbm_periph_model_i (.clk_sys(clk_sys), .rst_b(rst_b), .periph_in(periph_in),
    .periph_out(periph_out));

  // Expected {pull-up, drive enable, driven level} of the eight pins.
  function automatic logic [23:0] pad_exp(logic [7:0] d, logic [7:0] q, logic p,
      pbm_periph_en_type e, pbm_periph_out_type o);
    logic [7:0] pu, oe, v;
    oe = d;
    v = q;
    for (int i = 0; i < 8; i++) begin
      pu[i] = ({d[i], q[i], p} == 3'h2);
    end
    if (e.spi_on && e.spi_master_select) begin
      pu[6] = q[6] & ~p;
      oe[6] = 1'h0;
      v[5] = o.spi_sck_out;
      v[4] = o.spi_mosi_out;
    end
    if (e.spi_on && !e.spi_master_select) begin
      pu[5:4] = q[5:4] & {2{~p}};
      oe[5:4] = 2'h0;
      v[6] = o.spi_miso_out;
    end
    if (e.stage2_out2_on) begin
      {oe[7], v[7]} = {1'h1, o.stage2_pwm_out2};
    end
    if (e.stage_sec_out1_on) begin
      {oe[3], v[3]} = {1'h1, o.stage_sec_pwm_out1};
    end
    if (e.stage2_out1_on) begin
      {oe[2], v[2]} = {1'h1, o.stage2_pwm_out1};
    end
    if (e.stage2_out0_on) begin
      {oe[1], v[1]} = {1'h1, o.stage2_pwm_out0};
    end
    if (e.stage2_out3_on || e.cmp3_output_on) begin
      {oe[0], v[0]} = {1'h1, e.stage2_out3_on ? o.stage2_pwm_out3 : o.cmp3_result};
    end
    return {pu, oe, v & oe};
  endfunction

  // Expected digital input enable of the eight pins.
  function automatic logic [7:0] din_exp(pbm_periph_en_type e, pbm_conv_off_type c, logic s);
    logic [7:0] r;
    r = {8{~s}};
    r[7] = r[7] & ~c.conv_ch9_din_off;
    r[6] = r[6] & ~c.conv_ch8_din_off;
    r[5] = (c.conv_ch5_din_off | e.ext_irq1_on) ? e.ext_irq1_on : r[5];
    r[4] = r[4] & ~c.conv_ch3_din_off;
    r[3] = r[3] & ~c.conv_ch2_din_off;
    r[2] = e.ext_irq0_on ? 1'h1 : r[2];
    return r;
  endfunction

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("Compares %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Random inputs, with the first four settings fixed as corner cases.
  // Values are built first and driven once, so no half-applied setting shows.
  task automatic drive(input int n);
    logic [23:0] r;
    logic [3:0] m;
    pbm_periph_en_type e;
    r = 24'($urandom);
    m = 4'($urandom);
    e = pbm_periph_en_type'(10'($urandom));
    if (n < 2) begin
      r[23:8] = 16'hffff;
      m[3] = 1'h0;
      e = '{spi_on: 1'h1, spi_master_select: (n == 0), default: 1'h0};
    end else if (n == 2) begin
      e = '{stage2_out3_on: 1'h1, cmp3_output_on: 1'h1, default: 1'h0};
    end else if (n == 3) begin
      e = '{cmp3_output_on: 1'h1, default: 1'h0};
      {r[22], r[14]} = 2'h0;
    end
    {port_b_dir, port_b_out_data, pb_pad_in} = r;
    {global_pullup_disable, pd7_pad_in, pd4_pad_in, pd1_pad_in} = m;
    mcu_sleep = ($urandom % 4) == 0;
    periph_en = e;
    conv_off = pbm_conv_off_type'(7'($urandom));
  endtask

  // Watchdog sized well above the 300 blocks of seven cycles.
  initial begin
    #400000;
    err_total++;
    close_out();
  end

  // Main sequence: reset, then blocks of steady inputs.
  initial begin
    void'($urandom(6534));
    repeat (2) @(posedge clk_sys);
    #10;
    rst_b = 1'h1;
    check(24'({pb_pin_read, periph_in}), 24'h00_0000);
    for (int n = 0; n < 300; n++) begin
      @(posedge clk_sys);
      #10;
      drive(n);
      for (int k = 0; k < 6; k++) begin
        #10;
        check({pb_pullup_on, pb_pad_oe, pb_pad_out & pb_pad_oe}, pad_exp(port_b_dir,
          port_b_out_data, global_pullup_disable, periph_en, periph_out));
        @(posedge clk_sys);
        #10;
      end
      rd = pb_pad_in & din_exp(periph_en, conv_off, mcu_sleep);
      check(24'(pb_pin_read), 24'(rd));
      pe = {rd[7], rd[0], rd[2], rd[5], rd[6], rd[5], rd[4], pd7_pad_in &
        ~conv_off.conv_ch10_din_off, pd1_pad_in, pd4_pad_in & ~conv_off.conv_ch4_din_off};
      check(24'(periph_in[9:3]), 24'(pe[9:3]));
      check(24'(periph_in[2:0]), 24'(pe[2:0]));
    end
    close_out();
  end
endmodule

`default_nettype wire
